/* core/sssr_pkg.sv */
package sssr_pkg;
   // Summary byte bit positions.
   localparam int SB_ERRQ = 2;
   localparam int SB_MSG = 4;
   localparam int SB_ESB = 5;
   localparam int SB_MSS = 6;
   localparam int SB_OPER = 7;
   // Standard event flag bit positions.
   localparam int EV_OPC = 0;
   localparam int EV_RQC = 1;
   localparam int EV_QYE = 2;
   localparam int EV_DDE = 3;
   localparam int EV_EXE = 4;
   localparam int EV_CME = 5;
   localparam int EV_URQ = 6;
   localparam int EV_PON = 7;
   // Reset values of the masks and the event flags.
   localparam logic [7:0] MASK_RST = 8'h00;
   localparam logic [7:0] EVENT_RST = 8'h80;
   // Mask of the used summary bits; unused bits 0, 1 and 3 are zero.
   localparam logic [7:0] SB_USED = 8'hF4;
   // Query and command codes from the command parser.
   typedef enum logic [3:0] {
      SSSR_NOP, SSSR_RD_STB, SSSR_WR_SRE, SSSR_RD_SRE, SSSR_WR_PRE,
      SSSR_RD_PRE, SSSR_RD_ESR, SSSR_WR_ESE, SSSR_RD_ESE, SSSR_RD_IST
   } sssr_cmd_t;
   // A command from the parser with its data byte.
   typedef struct packed {
      logic valid;
      sssr_cmd_t code;
      logic [7:0] data;
   } sssr_req_t;
   // Operation complete and error events reported by the instrument.
   typedef struct packed {
      logic opc_done;
      logic query_err;
      logic device_err;
      logic exec_err;
      logic cmd_err;
   } sssr_evt_t;
   // Parallel poll configuration from the controller.
   typedef struct packed {
      logic [2:0] line;
      logic invert;
   } sssr_ppc_t;
endpackage

/* core/sssr_top.sv */
`timescale 1ns/1ps
// Function
// [RL1] Summary byte returned for query and poll
// [RL2] Request mask bit 6 ignored
// [RL3] Service request on masked rising summary bit
// [RL4] Request mask written and read back
// [RL5] Bit 2 set on error queue entry
// [RL6] Bit 4 while response message waits
// [RL7] Bit 5 from enabled event flags
// [RL8] Bit 6 is the master summary
// [RL9] Bit 7 from operation register summary
// [RL10] Status flag is OR of masked bits
// [RL11] Status flag for poll and query
// [RL12] Parallel poll mask written and read
// [RL13] Event flags returned on query
// [RL14] Event mask written and read back
// [RL15] Bit 0 set on completed operation
// [RL16] Event bits 1 and 6 never set
// [RL17] Bit 2 on query error
// [RL18] Bit 3 on device fault
// [RL19] Bit 4 on execution error
// [RL20] Bit 5 on command error
// [RL21] Bit 7 set at power on
// [RL22] Event flags cleared by reading them
// [RL23] Poll result on allocated line, maybe inverted
// [RL24] Summary bits 0, 1, 3 read zero
// [RL25] Message bit clears after last byte read
module sssr_top
   import sssr_pkg::*;
(
   input wire logic ref_clk, // Instrument clock, 100 MHz.
   input wire logic reset_n, // Power-on reset, active low.
   input wire sssr_pkg::sssr_req_t req, // Command from the parser.
   input wire sssr_pkg::sssr_evt_t evt, // Event pulses.
   input wire logic errq_not_empty, // Error queue holds an entry.
   input wire logic outbuf_avail, // Output buffer holds unread bytes.
   input wire logic oper_summary, // Operation register sum bit.
   input wire logic serial_poll, // Serial poll in progress.
   input wire logic par_poll, // Parallel poll in progress.
   input wire sssr_pkg::sssr_ppc_t ppc, // Parallel poll configuration.
   output logic [7:0] rsp_data, // Query or poll reply.
   output logic rsp_valid, // Reply strobe, one cycle.
   output logic srq_o, // Service request line level.
   output logic [7:0] pp_data_o, // Parallel poll data lines.
   output logic [7:0] pp_data_oe // Parallel poll drive enables.
);
   import sssr_pkg::*;

   // Stored state: three masks, the event flags and the edge memory for requests.
   logic [7:0] sre_r; // Service request mask.
   logic [7:0] pre_r; // Parallel poll mask.
   logic [7:0] esr_r; // Standard event flags.
   logic [7:0] ese_r; // Standard event mask.
   logic [7:0] stb_prev_r; // Summary bits seen last cycle.
   logic [7:0] stb_base; // Summary bits other than bit 6.
   logic [7:0] stb; // Full summary byte.
   logic individual_status_flag; // Individual status flag.
   logic [7:0] ev_set; // Event bits raised this cycle.

   // Summary bits; unused positions stay zero. Error queue and message bits follow
   // their sources, so the message bit drops as the last byte is collected.
   // Kept combinational so that queries, polls and the request logic see one byte.
   always_comb
   begin
      stb_base = 8'h00;
      stb_base[SB_ERRQ] = errq_not_empty; // RL5
      stb_base[SB_MSG] = outbuf_avail; // RL6 RL25
      stb_base[SB_ESB] = |(esr_r & ese_r); // RL7
      stb_base[SB_OPER] = oper_summary; // RL9
      stb_base = stb_base & SB_USED; // RL24
      stb = stb_base;
      // Mask bit 6 is ignored, so the summary can never feed itself.
      stb[SB_MSS] = |(stb_base & sre_r & ~8'h40); // RL8 RL2
      individual_status_flag = |(stb & pre_r); // RL10
   end

   // Event pulses mapped onto flag positions; bits 1 and 6 stay low.
   // Sources must pulse for one cycle; a level left high sets its flag again after a read.
   always_comb
   begin
      ev_set = 8'h00;
      ev_set[EV_OPC] = evt.opc_done; // RL15
      ev_set[EV_QYE] = evt.query_err; // RL17
      ev_set[EV_DDE] = evt.device_err; // RL18
      ev_set[EV_EXE] = evt.exec_err; // RL19
      ev_set[EV_CME] = evt.cmd_err; // RL20
      ev_set[EV_RQC] = 1'b0; // RL16
      ev_set[EV_URQ] = 1'b0; // RL16
   end

   // Mask registers loaded from their commands.
   // The masks keep their value through replies; only their own write changes them.
   // Bit 6 of the request mask is stored and read back although the logic ignores it.
   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         sre_r <= MASK_RST;
         pre_r <= MASK_RST;
         ese_r <= MASK_RST;
      end
      else if (req.valid)
      begin
         if (req.code == SSSR_WR_SRE)
            sre_r <= req.data; // RL4
         if (req.code == SSSR_WR_PRE)
            pre_r <= req.data; // RL12
         if (req.code == SSSR_WR_ESE)
            ese_r <= req.data; // RL14
      end
   end

   // Event flags: power-on bit at reset, read clears, a new event wins the clear.
   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
         esr_r <= EVENT_RST; // RL21
      // A read lost to a serial poll keeps the flags, so no event is dropped unseen.
      else if (req.valid && req.code == SSSR_RD_ESR && !serial_poll)
         esr_r <= ev_set; // RL22
      else
         esr_r <= esr_r | ev_set;
   end

   // Replies to queries and serial polls, one strobe each.
   // A serial poll wins over a query in the same cycle and the query is lost,
   // so the controller must not overlap the two.
   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         rsp_data <= 8'h00;
         rsp_valid <= 1'b0;
      end
      else if (serial_poll)
      begin
         rsp_data <= stb; // RL1
         rsp_valid <= 1'b1;
      end
      else if (req.valid && req.code != SSSR_NOP && req.code != SSSR_WR_SRE &&
               req.code != SSSR_WR_PRE && req.code != SSSR_WR_ESE)
      begin
         rsp_valid <= 1'b1;
         case (req.code)
            SSSR_RD_STB: rsp_data <= stb; // RL1
            SSSR_RD_SRE: rsp_data <= sre_r; // RL4
            SSSR_RD_PRE: rsp_data <= pre_r; // RL12
            SSSR_RD_ESR: rsp_data <= esr_r; // RL13
            SSSR_RD_ESE: rsp_data <= ese_r; // RL14
            SSSR_RD_IST: rsp_data <= {7'h00, individual_status_flag}; // RL11
            // Undefined codes answer zero rather than leave the controller waiting.
            default: rsp_data <= 8'h00;
         endcase
      end
      else
         rsp_valid <= 1'b0;
   end

   // Service request follows a masked rising summary bit and holds while
   // any enabled bit stays set; the rising edge is what makes it assert.
   // The edge memory resets to zero; with every mask cleared at reset no false
   // request can follow the release.
   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         stb_prev_r <= 8'h00;
         srq_o <= 1'b0;
      end
      else
      begin
         stb_prev_r <= stb_base;
         if (|(stb_base & ~stb_prev_r & sre_r & ~8'h40))
            srq_o <= 1'b1; // RL3
         else if (!stb[SB_MSS])
            srq_o <= 1'b0;
      end
   end

   // Parallel poll drives only the allocated line, inverted on request.
   // Every other line is released each cycle, so a change of allocation
   // never leaves two lines driven.
   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         pp_data_o <= 8'h00;
         pp_data_oe <= 8'h00;
      end
      else
      begin
         pp_data_o <= 8'h00;
         pp_data_oe <= 8'h00;
         if (par_poll)
         begin
            pp_data_o[ppc.line] <= individual_status_flag ^ ppc.invert; // RL23 RL11
            pp_data_oe[ppc.line] <= 1'b1;
         end
      end
   end

   // Checks next to the logic. Each property names its own clock and reset, so
   // the block needs no default clocking in whatever bench it is placed.
   // Replies are checked one edge after the taking edge, where they stand.
   // A masked rising summary bit must raise the request on the next edge.
   a_srq_on_rise: assert property (@(posedge ref_clk) disable iff (!reset_n) // RL3
      (|(stb_base & ~stb_prev_r & sre_r & 8'hBF)) |=> srq_o)
      else $error("Service request missing after masked rise.");

   // With no enabled summary bit left the request must fall on the next edge.
   a_srq_release: assert property (@(posedge ref_clk) disable iff (!reset_n) // RL3
      !stb[SB_MSS] |=> !srq_o)
      else $error("Service request held without an enabled bit.");

   // A read leaves only the events of that same cycle, since a set beats the clear.
   a_esr_read_clear: assert property (@(posedge ref_clk) disable iff (!reset_n) // RL22
      (req.valid && req.code == SSSR_RD_ESR && !serial_poll) |=> esr_r == $past(ev_set))
      else $error("Event flags not cleared by read.");

   // Vacant summary positions must read zero in a serial poll reply.
   a_unused_zero: assert property (@(posedge ref_clk) disable iff (!reset_n) // RL24
      (rsp_valid && $past(serial_poll)) |-> (rsp_data & 8'h0B) == 8'h00)
      else $error("Unused summary bits not zero.");

   // Request control and user request are not implemented, so their flags stay low.
   a_ev_never_set: assert property (@(posedge ref_clk) disable iff (!reset_n) // RL16
      esr_r[EV_RQC] == 1'b0 && esr_r[EV_URQ] == 1'b0)
      else $error("Unused event bits set.");

   // Each mask takes the data byte of its write command on the next edge.
   a_sre_load: assert property (@(posedge ref_clk) disable iff (!reset_n) // RL4
      (req.valid && req.code == SSSR_WR_SRE) |=> sre_r == $past(req.data))
      else $error("Request mask not loaded.");
   a_pre_load: assert property (@(posedge ref_clk) disable iff (!reset_n) // RL12
      (req.valid && req.code == SSSR_WR_PRE) |=> pre_r == $past(req.data))
      else $error("Parallel poll mask not loaded.");
   a_ese_load: assert property (@(posedge ref_clk) disable iff (!reset_n) // RL14
      (req.valid && req.code == SSSR_WR_ESE) |=> ese_r == $past(req.data))
      else $error("Event mask not loaded.");

   // An operation complete pulse must leave its flag set, even across a read.
   a_opc_flag: assert property (@(posedge ref_clk) disable iff (!reset_n) // RL15
      evt.opc_done |=> esr_r[0])
      else $error("Operation complete flag missing.");
   // Every error pulse must land on its own flag position.
   a_err_flags: assert property (@(posedge ref_clk) disable iff (!reset_n) // RL17 RL18 RL19 RL20
      (evt.query_err || evt.device_err || evt.exec_err || evt.cmd_err) |=>
      ((!$past(evt.query_err) || esr_r[EV_QYE]) && (!$past(evt.device_err) || esr_r[EV_DDE]) &&
      (!$past(evt.exec_err) || esr_r[EV_EXE]) && (!$past(evt.cmd_err) || esr_r[EV_CME])))
      else $error("Event pulse did not set its flag.");

   // The master bit must appear in a poll whenever an enabled bit is set.
   a_mss_form: assert property (@(posedge ref_clk) disable iff (!reset_n) // RL8
      (serial_poll && (stb_base & sre_r & 8'hBF) != 8'h00) |=> rsp_data[6])
      else $error("Master summary bit missing in poll.");
   // A mask holding only bit 6 must never produce a master summary.
   a_mask6_ignored: assert property (@(posedge ref_clk) disable iff (!reset_n) // RL2
      (sre_r == 8'h40) |-> !stb[SB_MSS])
      else $error("Request mask bit 6 was not ignored.");

   // A summary query or a serial poll returns the byte that stood at the taking edge.
   a_stb_query: assert property (@(posedge ref_clk) disable iff (!reset_n) // RL1
      (req.valid && req.code == SSSR_RD_STB && !serial_poll) |=>
      rsp_valid && rsp_data == $past(stb))
      else $error("Summary query reply wrong.");
   a_poll_reply: assert property (@(posedge ref_clk) disable iff (!reset_n) // RL1
      serial_poll |=> rsp_valid && rsp_data == $past(stb))
      else $error("Serial poll reply wrong.");
   // The summary sources land on their own positions of the reply.
   a_stb_sources: assert property (@(posedge ref_clk) disable iff (!reset_n) // RL5 RL6 RL9 RL25
      (req.valid && req.code == SSSR_RD_STB && !serial_poll) |=>
      (rsp_data[SB_ERRQ] == $past(errq_not_empty) && rsp_data[SB_MSG] == $past(outbuf_avail) &&
      rsp_data[SB_OPER] == $past(oper_summary)))
      else $error("Summary source bit misplaced.");
   a_esb_form: assert property (@(posedge ref_clk) disable iff (!reset_n) // RL7
      (req.valid && req.code == SSSR_RD_STB && !serial_poll) |=>
      rsp_data[SB_ESB] == $past(|(esr_r & ese_r)))
      else $error("Event summary bit wrong.");
   a_stb_vacant: assert property (@(posedge ref_clk) disable iff (!reset_n) // RL24
      (req.valid && req.code == SSSR_RD_STB && !serial_poll) |=> (rsp_data & 8'h0B) == 8'h00)
      else $error("Vacant summary bits not zero in query.");

   // Event flag and status flag queries reply with the values at the taking edge.
   a_esr_query: assert property (@(posedge ref_clk) disable iff (!reset_n) // RL13
      (req.valid && req.code == SSSR_RD_ESR && !serial_poll) |=> rsp_data == $past(esr_r))
      else $error("Event flag reply wrong.");
   a_ist_query: assert property (@(posedge ref_clk) disable iff (!reset_n) // RL10 RL11
      (req.valid && req.code == SSSR_RD_IST && !serial_poll) |=>
      rsp_data == {7'h00, $past(|(stb & pre_r))})
      else $error("Status flag reply wrong.");

   // Writes and idle cycles must not produce a reply strobe.
   a_write_silent: assert property (@(posedge ref_clk) disable iff (!reset_n) // RL4 RL12 RL14
      (!serial_poll && (!req.valid || req.code == SSSR_NOP || req.code == SSSR_WR_SRE ||
      req.code == SSSR_WR_PRE || req.code == SSSR_WR_ESE)) |=> !rsp_valid)
      else $error("Reply strobe without a query.");

   // Only the allocated line is enabled during a poll, and it carries the flag.
   a_pp_drive: assert property (@(posedge ref_clk) disable iff (!reset_n) // RL23
      par_poll |=> pp_data_oe == (8'h01 << $past(ppc.line)))
      else $error("Parallel poll line not driven.");
   a_pp_value: assert property (@(posedge ref_clk) disable iff (!reset_n) // RL11 RL23
      par_poll |=> pp_data_o == ($past(individual_status_flag ^ ppc.invert) ? (8'h01 << $past(ppc.line)) : 8'h00))
      else $error("Parallel poll value wrong.");
   // Outside a poll no line may be driven.
   a_pp_idle: assert property (@(posedge ref_clk) disable iff (!reset_n) // RL23
      !par_poll |=> pp_data_oe == 8'h00)
      else $error("Parallel poll line driven while idle.");
endmodule

/* dv/sssr_ctrl_model.sv */
`timescale 1ns/1ps
// Bus controller model; it issues one command or poll at a time, as a test program would.
module sssr_ctrl_model
   import sssr_pkg::*;
(
   input wire logic ref_clk, // Instrument clock.
   input wire logic [7:0] rsp_data, // Reply byte from the device.
   input wire logic rsp_valid, // Reply strobe from the device.
   output sssr_pkg::sssr_req_t req, // Command to the device.
   output logic serial_poll, // Serial poll request.
   output logic par_poll, // Parallel poll request.
   output sssr_pkg::sssr_ppc_t ppc // Allocated poll line and sense.
);
   // Everything idle from time zero.
   initial
   begin
      req = '0;
      serial_poll = 1'b0;
      par_poll = 1'b0;
      ppc = '0;
   end
   // Sends one command and takes the reply one edge later.
   // Data is inverted once released, so a stale value cannot pass for a live one.
   task automatic xfer(input sssr_cmd_t code, input logic [7:0] d, output logic [8:0] r);
      @(posedge ref_clk) #1;
      req = sssr_req_t'({1'b1, code, d});
      @(posedge ref_clk) #1;
      r = {rsp_valid, rsp_data};
      req = sssr_req_t'({1'b0, SSSR_NOP, ~d});
   endtask
   // Holds a serial or parallel poll for one cycle and takes the reply.
   task automatic poll(input logic ser, input sssr_ppc_t c, output logic [8:0] r);
      @(posedge ref_clk) #1;
      serial_poll = ser;
      par_poll = ~ser;
      ppc = c;
      @(posedge ref_clk) #1;
      r = {rsp_valid, rsp_data};
      serial_poll = 1'b0;
      par_poll = 1'b0;
   endtask
endmodule

/* dv/sssr_top_tb_top.sv */
`timescale 1ns/1ps
// Self-checking bench; commands go through the controller model.
module sssr_top_tb_top;
   import sssr_pkg::*;
   logic ref_clk, reset_n, errq_not_empty, outbuf_avail, oper_summary;
   logic srq_o, rsp_valid, serial_poll, par_poll;
   logic [7:0] rsp_data, pp_data_o, pp_data_oe;
   logic [8:0] r; // Reply with its strobe on top.
   sssr_req_t req;
   sssr_evt_t evt;
   sssr_ppc_t ppc;
   int bad_count = 0;
   int n_compared = 0;
   // Flag expected for each event pulse, cmd_err first.
   localparam logic [7:0] EV_EXP [5] = '{8'h20, 8'h10, 8'h08, 8'h04, 8'h01};
   sssr_top u_sssr_top (.ref_clk(ref_clk), .reset_n(reset_n), .req(req), .evt(evt),
      .errq_not_empty(errq_not_empty), .outbuf_avail(outbuf_avail),
      .oper_summary(oper_summary), .serial_poll(serial_poll), .par_poll(par_poll),
      .ppc(ppc), .rsp_data(rsp_data), .rsp_valid(rsp_valid), .srq_o(srq_o),
      .pp_data_o(pp_data_o), .pp_data_oe(pp_data_oe));
   sssr_ctrl_model u_sssr_ctrl_model (.ref_clk(ref_clk), .rsp_data(rsp_data),
      .rsp_valid(rsp_valid), .req(req), .serial_poll(serial_poll), .par_poll(par_poll),
      .ppc(ppc));
   // Free-running 100 MHz clock.
   initial
   begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   // Compares a 9-bit result; unknowns never match.
   task automatic cmp(input logic [8:0] got, input logic [8:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         bad_count++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // A query must answer with the strobe set.
   task automatic rd(input sssr_cmd_t c, input logic [7:0] exp);
      u_sssr_ctrl_model.xfer(c, 8'h00, r);
      cmp(r, {1'b1, exp});
   endtask
   // A write must stay silent: its strobe is checked, its stale data is not.
   task automatic wr(input sssr_cmd_t c, input logic [7:0] d);
      u_sssr_ctrl_model.xfer(c, d, r);
      cmp({8'h00, r[8]}, 9'h000);
   endtask
   task automatic tally_and_finish();
      $display("compared=%0d mismatches=%0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0)
      begin
         $display("RESULT: PASS");
      end
      else
      begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // Guards against a hang anywhere in the sequence.
   initial
   begin
      #200000;
      bad_count++;
      tally_and_finish();
   end
   // Main sequence.
   initial
   begin
      reset_n = 1'b0;
      evt = '0;
      errq_not_empty = 1'b0;
      outbuf_avail = 1'b0;
      oper_summary = 1'b0;
      repeat (3) @(posedge ref_clk);
      #1 reset_n = 1'b1;
      rd(SSSR_RD_ESR, 8'h80);
      rd(SSSR_RD_ESR, 8'h00);
      wr(SSSR_WR_SRE, 8'hFF);
      rd(SSSR_RD_SRE, 8'hFF);
      wr(SSSR_WR_ESE, 8'hFF);
      rd(SSSR_RD_ESE, 8'hFF);
      wr(SSSR_WR_PRE, 8'h5A);
      rd(SSSR_RD_PRE, 8'h5A);
      outbuf_avail = 1'b1;
      repeat (3) @(posedge ref_clk);
      #1 cmp({8'h00, srq_o}, 9'h001);
      rd(SSSR_RD_STB, 8'h50);
      u_sssr_ctrl_model.poll(1'b1, '0, r);
      cmp(r, 9'h150);
      outbuf_avail = 1'b0;
      rd(SSSR_RD_STB, 8'h00);
      cmp({8'h00, srq_o}, 9'h000);
      wr(SSSR_WR_SRE, 8'h40);
      errq_not_empty = 1'b1;
      rd(SSSR_RD_STB, 8'h04);
      cmp({8'h00, srq_o}, 9'h000);
      errq_not_empty = 1'b0;
      wr(SSSR_WR_SRE, 8'h00);
      // Each event alone: summary bit 5 first, then the flag, which the read clears.
      for (int i = 0; i < 5; i++)
      begin
         evt = sssr_evt_t'(5'(1 << i));
         @(posedge ref_clk) #1;
         evt = '0;
         rd(SSSR_RD_STB, 8'h20);
         rd(SSSR_RD_ESR, EV_EXP[i]);
      end
      oper_summary = 1'b1;
      wr(SSSR_WR_SRE, 8'h80);
      wr(SSSR_WR_PRE, 8'h40);
      rd(SSSR_RD_STB, 8'hC0);
      rd(SSSR_RD_IST, 8'h01);
      // Parallel poll on line 3, plain and inverted.
      for (int k = 0; k < 2; k++)
      begin
         u_sssr_ctrl_model.poll(1'b0, sssr_ppc_t'({3'h3, k[0]}), r);
         cmp({1'b0, pp_data_oe}, 9'h008);
         cmp({8'h00, pp_data_o[3]}, {8'h00, ~k[0]});
      end
      wr(SSSR_WR_PRE, 8'h0B);
      rd(SSSR_RD_IST, 8'h00);
      // Second power-up in mid-run: no request, request mask clear, power-on flag again.
      reset_n = 1'b0;
      repeat (2) @(posedge ref_clk);
      #1 reset_n = 1'b1;
      cmp({8'h00, srq_o}, 9'h000);
      rd(SSSR_RD_SRE, 8'h00);
      rd(SSSR_RD_ESR, 8'h80);
      tally_and_finish();
   end
endmodule
